// ===== csbr_pkg.sv
// Shared types and constants for the core system bus router
package csbr_pkg;
    // Bus widths
    localparam int PAB_W  = 21;
    localparam int XAB_W  = 24;
    localparam int WIDE_W = 32;
    localparam int NAR_W  = 16;

    // Decode boundary: addresses at or above this go to the peripheral bus
    localparam logic [23:0] PERIPH_BASE = 24'hFFF000;
    // Mask that clears the most significant address bit for byte accesses
    localparam logic [23:0] BYTE_ADDR_MASK = 24'h7FFFFF;
    // Reset values
    localparam logic [31:0] RST_DATA32 = 32'h00000000;
    localparam logic [15:0] RST_DATA16 = 16'h0000;
    localparam logic [23:0] RST_ADDR24 = 24'h000000;

    // Access sizes on the primary path
    typedef enum logic [1:0] {
        CSBR_SZ_BYTE = 2'b00,
        CSBR_SZ_WORD = 2'b01,
        CSBR_SZ_LONG = 2'b10
    } csbr_size_t;

    // Primary request as the core issues it
    typedef struct packed {
        logic        valid;
        logic        write;
        csbr_size_t  size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } csbr_preq_t;

    // Memory-side request toward a target
    typedef struct packed {
        logic        en;
        logic        write;
        csbr_size_t  size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } csbr_tgt_t;
endpackage

// ===== csbr_decode.sv
// Primary data address decode and byte-address fix-up
`timescale 1ns/100ps
`default_nettype none
module csbr_decode (
    // Raw request
    input  wire csbr_pkg::csbr_preq_t req,
    // Decoded outputs
    output var  logic [23:0]          addr_fixed,
    output var  logic                 sel_mem,
    output var  logic                 sel_periph
);
    // Byte accesses cannot reach the upper half, so force bit 23 low
    always_comb begin
        if (req.size == csbr_pkg::CSBR_SZ_BYTE) begin
            addr_fixed = req.addr & csbr_pkg::BYTE_ADDR_MASK; // [R04]
        end else begin
            addr_fixed = req.addr;
        end
    end

    // One target only per access
    always_comb begin
        sel_mem    = 1'b0;
        sel_periph = 1'b0;
        if (!req.valid) begin
            sel_mem    = 1'b0;
        end else if (addr_fixed >= csbr_pkg::PERIPH_BASE) begin
            sel_periph = 1'b1; // [R10]
        end else begin
            sel_mem    = 1'b1; // [R10]
        end
    end
endmodule
`default_nettype wire

// ===== csbr_router.sv
// Top of the core system bus router: program, primary, secondary and peripheral paths
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R01] 21-bit program address returns 16-bit word
// [R02] Program writes use low 16 write bits
// [R03] Primary 24-bit path: byte, word, long
// [R04] Byte accesses force address MSB low
// [R05] Secondary path reads whole 16-bit words
// [R06] Peripheral bus 16-bit, no added delay
// [R07] Primary RAM 32 bits, others 16
// [R08] Flash control via peripheral bus; array direct
// [R09] Three concurrent accesses in one cycle
// [R10] Decode primary address; enable one target
module csbr_router (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Program path from the core
    input  wire logic                 prog_valid,
    input  wire logic                 prog_write,
    input  wire logic [20:0]          prog_addr,
    output logic      [15:0]          prog_read_data,
    // Primary data path from the core
    input  wire csbr_pkg::csbr_preq_t primary_req,
    input  wire logic [31:0]          core_write_data,
    output logic      [31:0]          primary_read_data,
    // Secondary read path from the core
    input  wire logic                 sec_valid,
    input  wire logic [23:0]          secondary_data_address,
    output logic      [15:0]          secondary_read_data,
    // Program memory port
    output logic                      pmem_en,
    output logic                      pmem_write,
    output logic      [20:0]          pmem_addr,
    output logic      [15:0]          pmem_wdata,
    input  wire logic [15:0]          pmem_rdata,
    // Primary data RAM port, 32 bits wide
    output csbr_pkg::csbr_tgt_t       dram_req,
    input  wire logic [31:0]          dram_rdata,
    // Secondary data RAM port, 16 bits wide
    output logic                      dram2_en,
    output logic      [23:0]          dram2_addr,
    input  wire logic [15:0]          dram2_rdata,
    // Peripheral register bus, carries flash control too
    output csbr_pkg::csbr_tgt_t       periph_req,
    input  wire logic [15:0]          periph_rdata
);
    // Decoded primary address and target selects
    logic [23:0]          primary_data_address;
    logic                 sel_mem;
    logic                 sel_periph;
    csbr_pkg::csbr_preq_t preq_eff;
    // Which targets answer a primary, secondary or program read one cycle later
    logic                 rd_periph_ff;
    logic                 rd_mem_ff;
    logic                 rd_sec_ff;
    logic                 rd_prog_ff;

    // Write data always comes from the shared core write bus
    always_comb begin
        preq_eff       = primary_req;
        preq_eff.wdata = core_write_data; // [R03]
    end

    csbr_decode u_decode (
        .req        (preq_eff),
        .addr_fixed (primary_data_address),
        .sel_mem    (sel_mem),
        .sel_periph (sel_periph)
    );

    // Program memory request; registered so outputs come from flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pmem_en    <= 1'b0;
            pmem_write <= 1'b0;
            pmem_addr  <= '0;
            pmem_wdata <= csbr_pkg::RST_DATA16;
        end else begin
            pmem_en    <= prog_valid; // [R01]
            pmem_write <= prog_valid & prog_write;
            pmem_addr  <= prog_addr; // [R01]
            // Upper half of the write bus is dropped on purpose
            pmem_wdata <= core_write_data[15:0]; // [R02]
        end
    end

    // Primary RAM request; flash array accesses live in this map as well
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dram_req <= '0;
        end else begin
            dram_req.en    <= sel_mem; // [R10] [R08]
            dram_req.write <= preq_eff.write & sel_mem;
            dram_req.size  <= preq_eff.size; // [R03]
            dram_req.addr  <= primary_data_address; // [R04]
            dram_req.wdata <= preq_eff.wdata; // [R07]
        end
    end

    // Peripheral request; only the low 16 data bits exist there
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_req <= '0;
        end else begin
            periph_req.en    <= sel_periph; // [R10] [R08]
            periph_req.write <= preq_eff.write & sel_periph;
            periph_req.size  <= preq_eff.size;
            periph_req.addr  <= primary_data_address;
            periph_req.wdata <= {16'h0000, preq_eff.wdata[15:0]}; // [R06] [R07]
        end
    end

    // Secondary read request, issued alongside the other two paths
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dram2_en   <= 1'b0;
            dram2_addr <= csbr_pkg::RST_ADDR24;
        end else begin
            dram2_en   <= sec_valid; // [R05] [R09]
            dram2_addr <= secondary_data_address; // [R05]
        end
    end

    // Targets answer one cycle after their enable, like a synchronous RAM
    // Track which targets owe read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_periph_ff <= 1'b0;
            rd_mem_ff    <= 1'b0;
            rd_sec_ff    <= 1'b0;
            rd_prog_ff   <= 1'b0;
        end else begin
            rd_periph_ff <= periph_req.en & ~periph_req.write;
            rd_mem_ff    <= dram_req.en & ~dram_req.write;
            rd_sec_ff    <= dram2_en;
            rd_prog_ff   <= pmem_en & ~pmem_write;
        end
    end

    // Return read data; peripheral path has the same latency as RAM
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_read_data <= csbr_pkg::RST_DATA32;
        end else if (rd_periph_ff) begin
            primary_read_data <= {16'h0000, periph_rdata}; // [R06]
        end else if (rd_mem_ff) begin
            primary_read_data <= dram_rdata; // [R03]
        end
    end

    // Secondary and program read data held until the next read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            secondary_read_data <= csbr_pkg::RST_DATA16;
            prog_read_data      <= csbr_pkg::RST_DATA16;
        end else begin
            if (rd_sec_ff) begin
                secondary_read_data <= dram2_rdata; // [R05]
            end
            if (rd_prog_ff) begin
                prog_read_data <= pmem_rdata; // [R01]
            end
        end
    end

    // Checks on the guarded paths
    a_byte_msb_low: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
        (primary_req.valid && primary_req.size == csbr_pkg::CSBR_SZ_BYTE)
        |=> !dram_req.addr[23] && !periph_req.addr[23])
        else $error("byte access kept address msb");
    a_one_target: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        !(dram_req.en && periph_req.en))
        else $error("two targets enabled");
    a_valid_reaches: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        primary_req.valid |=> (dram_req.en || periph_req.en))
        else $error("primary access selected no target");
    a_prog_low_half: assert property (@(posedge core_clk) disable iff (!rst_n) // [R02]
        prog_valid |=> pmem_wdata == $past(core_write_data[15:0]))
        else $error("program write data not low half");
    a_prog_addr_pass: assert property (@(posedge core_clk) disable iff (!rst_n) // [R01]
        prog_valid |=> pmem_en && pmem_addr == $past(prog_addr))
        else $error("program address not forwarded");
    sequence s_sec_issue;
        sec_valid ##1 dram2_en;
    endsequence
    a_sec_return: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
        s_sec_issue ##1 1'b1 |=> secondary_read_data == $past(dram2_rdata))
        else $error("secondary read data not returned");
    a_periph_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R06]
        periph_req.wdata[31:16] == 16'h0000)
        else $error("peripheral write data wider than 16 bits");
    a_periph_nodelay: assert property (@(posedge core_clk) disable iff (!rst_n) // [R06]
        (periph_req.en && !periph_req.write) ##1 1'b1 |=>
        primary_read_data == {16'h0000, $past(periph_rdata)})
        else $error("peripheral read data late or wrong");
    a_three_parallel: assert property (@(posedge core_clk) disable iff (!rst_n) // [R09]
        (prog_valid && sec_valid && primary_req.valid) |=>
        (pmem_en && dram2_en && (dram_req.en || periph_req.en)))
        else $error("concurrent accesses not all issued");

    // Read returns land two edges after the target enable
    sequence s_prog_read;
        (pmem_en && !pmem_write) ##1 1'b1;
    endsequence
    sequence s_mem_read;
        (dram_req.en && !dram_req.write) ##1 1'b1;
    endsequence
    a_prog_return: assert property (@(posedge core_clk) disable iff (!rst_n) // [R01]
        s_prog_read |=> prog_read_data == $past(pmem_rdata))
        else $error("program read data not returned");
    a_mem_return: assert property (@(posedge core_clk) disable iff (!rst_n) // [R03]
        s_mem_read |=> primary_read_data == $past(dram_rdata))
        else $error("primary read data not returned");
    // Only the chosen target may see a write strobe
    a_write_gated: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        !(dram_req.write && !dram_req.en) && !(periph_req.write && !periph_req.en))
        else $error("write strobe on an unselected target");
    // Secondary address goes out unchanged with its enable
    a_sec_addr_pass: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
        sec_valid |=> dram2_en && dram2_addr == $past(secondary_data_address))
        else $error("secondary address not forwarded");
endmodule
`default_nettype wire

// ===== csbr_mem_model.sv
// Behavioural memories and peripheral bridge on the router's far side
`timescale 1ns/100ps
`default_nettype none
module csbr_mem_model (
    // Clock
    input  wire logic                core_clk,
    // Target requests from the router
    input  wire logic                pmem_en,
    input  wire logic [20:0]         pmem_addr,
    input  wire csbr_pkg::csbr_tgt_t dram_req,
    input  wire csbr_pkg::csbr_tgt_t periph_req,
    input  wire logic                dram2_en,
    input  wire logic [23:0]         dram2_addr,
    // Read answers
    output logic      [15:0]         pmem_rdata,
    output logic      [31:0]         dram_rdata,
    output logic      [15:0]         dram2_rdata,
    output logic      [15:0]         periph_rdata
);
    // Pattern shown by idle targets, so stale data never looks valid
    logic [15:0] churn_ff = 16'h1234;

    // Churn advances every cycle
    always_ff @(posedge core_clk) begin
        churn_ff <= churn_ff + 16'h3C5B;
    end

    // Synchronous targets: address taken at the enable edge, data stands the next cycle
    // The router captures two edges after the enable, so a same-cycle answer would be lost
    always_ff @(posedge core_clk) begin
        pmem_rdata   <= pmem_en ? (pmem_addr[15:0] ^ 16'hA5A5) : churn_ff;
        dram_rdata   <= dram_req.en ? {dram_req.addr[15:0], ~dram_req.addr[15:0]}
                                    : {churn_ff, ~churn_ff};
        dram2_rdata  <= dram2_en ? (dram2_addr[15:0] + 16'h1234) : ~churn_ff;
        periph_rdata <= periph_req.en ? (periph_req.addr[15:0] ^ 16'h5A5A) : churn_ff;
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the core system bus router
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                core_clk, rst_n, pv, pw, sv, pmem_en, pmem_write, dram2_en;
    logic [20:0]         pa, pmem_addr;
    logic [23:0]         sa, dram2_addr;
    logic [15:0]         prd, srd, pmem_wdata, pmem_rdata, dram2_rdata, periph_rdata;
    logic [31:0]         wd, qrd, dram_rdata;
    csbr_pkg::csbr_preq_t q;
    csbr_pkg::csbr_tgt_t  dram_req, periph_req;
    int                  fail_count, check_count, cyc;

    csbr_router u_dut (.core_clk(core_clk), .rst_n(rst_n), .prog_valid(pv), .prog_write(pw),
        .prog_addr(pa), .prog_read_data(prd), .primary_req(q), .core_write_data(wd),
        .primary_read_data(qrd), .sec_valid(sv), .secondary_data_address(sa),
        .secondary_read_data(srd), .pmem_en(pmem_en), .pmem_write(pmem_write),
        .pmem_addr(pmem_addr), .pmem_wdata(pmem_wdata), .pmem_rdata(pmem_rdata),
        .dram_req(dram_req), .dram_rdata(dram_rdata), .dram2_en(dram2_en),
        .dram2_addr(dram2_addr), .dram2_rdata(dram2_rdata), .periph_req(periph_req),
        .periph_rdata(periph_rdata));
    csbr_mem_model u_mem (.core_clk(core_clk), .pmem_en(pmem_en), .pmem_addr(pmem_addr),
        .dram_req(dram_req), .periph_req(periph_req), .dram2_en(dram2_en),
        .dram2_addr(dram2_addr), .pmem_rdata(pmem_rdata), .dram_rdata(dram_rdata),
        .dram2_rdata(dram2_rdata), .periph_rdata(periph_rdata));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end

    // Issue the staged requests, check targets, then read answers
    task automatic go();
        logic [23:0] a;
        logic        per, pr, qr, sr;
        a = (q.size == csbr_pkg::CSBR_SZ_BYTE) ? {1'b0, q.addr[22:0]} : q.addr;
        per = (a >= csbr_pkg::PERIPH_BASE);
        pr = pv & ~pw;
        qr = q.valid & ~q.write;
        sr = sv;
        @(posedge core_clk);
        #1;
        chk(pmem_en, pv);
        if (pv) chk(pmem_addr, pa);
        if (pv) chk(pmem_write, pw);
        if (pv & pw) chk(pmem_wdata, wd[15:0]);
        chk(dram2_en, sv);
        if (sv) chk(dram2_addr, sa);
        chk(dram_req.en, q.valid & ~per);
        chk(periph_req.en, q.valid & per);
        if (q.valid) chk(per ? periph_req.addr : dram_req.addr, a);
        if (q.valid) chk(per ? periph_req.write : dram_req.write, q.write);
        if (q.valid & ~per) chk(dram_req.size, q.size);
        if (q.valid & q.write) chk(per ? periph_req.wdata : dram_req.wdata,
                                   per ? {16'h0000, wd[15:0]} : wd);
        pv = 1'b0;
        sv = 1'b0;
        q.valid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        if (pr) chk(prd, pa[15:0] ^ 16'hA5A5);
        if (sr) chk(srd, sa[15:0] + 16'h1234);
        if (qr & per) chk(qrd[15:0], a[15:0] ^ 16'h5A5A);
        if (qr & ~per) chk(qrd, {a[15:0], ~a[15:0]});
    endtask

    // Stage a primary access
    task automatic stage(input logic w, input logic [1:0] s, input logic [23:0] ad);
        q.valid = 1'b1;
        q.write = w;
        q.size = csbr_pkg::csbr_size_t'(s);
        q.addr = ad;
        q.wdata = ~wd;
        wd = $urandom;
    endtask

    initial begin
        fail_count = 0;
        check_count = 0;
        cyc = 0;
        rst_n = 1'b0;
        {pv, pw, sv, pa, sa, wd} = '0;
        q = '0;
        void'($urandom(84));
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        // Three-way concurrent reads, all sizes, random addresses
        for (int i = 0; i < 12; i++) begin
            pv = 1'b1;
            pa = 21'($urandom);
            sv = 1'b1;
            sa = 24'($urandom);
            stage(1'b0, 2'(i % 3), 24'($urandom));
            go();
        end
        $display("concurrent reads done");
        // Writes on program and primary paths, every size
        for (int i = 0; i < 3; i++) begin
            pv = 1'b1;
            pw = 1'b1;
            pa = 21'($urandom);
            stage(1'b1, 2'(i), 24'($urandom) | 24'h800000);
            go();
        end
        pw = 1'b0;
        $display("writes done");
        // Byte in upper half lands in memory; word there reaches the bridge
        stage(1'b0, 2'b00, 24'hFFF800);
        go();
        stage(1'b1, 2'b00, 24'hFFFFFF);
        go();
        stage(1'b0, 2'b01, csbr_pkg::PERIPH_BASE);
        go();
        stage(1'b1, 2'b01, 24'hFFFFFE);
        go();
        stage(1'b0, 2'b01, csbr_pkg::PERIPH_BASE - 24'h000001);
        go();
        $display("decode and byte fix-up done");
        // Reset in mid-run: outputs clear, then the first request after release is served
        pv = 1'b1;
        pa = 21'($urandom);
        sv = 1'b1;
        sa = 24'($urandom);
        stage(1'b0, 2'b10, 24'($urandom) & 24'h7FFFFF);
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        pv = 1'b0;
        sv = 1'b0;
        q.valid = 1'b0;
        #1;
        chk(qrd, csbr_pkg::RST_DATA32);
        chk(prd, csbr_pkg::RST_DATA16);
        chk(srd, csbr_pkg::RST_DATA16);
        chk({pmem_en, dram2_en, dram_req.en, periph_req.en}, 32'h0);
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        pv = 1'b1;
        pa = 21'($urandom);
        sv = 1'b1;
        sa = 24'($urandom);
        stage(1'b0, 2'b01, 24'($urandom));
        go();
        $display("mid-run reset done");
        close_out();
    end
endmodule
`default_nettype wire
